// *** src/msm_pkg.sv ***
// Shared types and constants of the memory attribute and security map
package msm_pkg;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MT_NORMAL     = 2'h0,
        MT_DEV_EARLY  = 2'h1,
        MT_DEV_STRICT = 2'h2
    } msm_mtype_t;

    typedef enum logic [1:0] {
        CP_NONE = 2'h0,
        CP_WT   = 2'h1,
        CP_WRITE_BACK_WRITE_ALLOCATE = 2'h2
    } msm_cache_t;

    typedef enum logic [1:0] {
        AK_FETCH = 2'h0,
        AK_LOAD  = 2'h1,
        AK_STORE = 2'h2
    } msm_kind_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_ADDR = 3'h2,
        S_DATA = 3'h4
    } msm_state_t;

    typedef struct packed {
        msm_mtype_t mtype;
        logic       shareable;
        logic       execute_never;
        msm_cache_t cache;
    } msm_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        msm_kind_t   kind;
        logic [1:0]  size;
        logic [31:0] wdata;
    } msm_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        sec_fault;
        logic        mm_fault;
        logic        gateway_ok;
        logic        bus_err;
    } msm_rsp_t;

    // ==========================================================
    // Default map boundaries
    localparam logic [31:0] MAP_SRAM   = 32'h2000_0000;
    localparam logic [31:0] MAP_PERIPH = 32'h4000_0000;
    localparam logic [31:0] MAP_RAM    = 32'h6000_0000;
    localparam logic [31:0] MAP_RAM_HI = 32'h8000_0000;
    localparam logic [31:0] MAP_EXTDEV = 32'ha000_0000;
    localparam logic [31:0] MAP_PPB    = 32'he000_0000;

    // ==========================================================
    // Register offsets and fields
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_FADDR    = 8'h08;
    localparam logic [7:0] OFS_SAU      = 8'h10;
    localparam logic [7:0] OFS_MPU_NS_B = 8'h40;
    localparam logic [7:0] OFS_MPU_NS_L = 8'h44;
    localparam logic [7:0] OFS_MPU_S_B  = 8'h48;
    localparam logic [7:0] OFS_MPU_S_L  = 8'h4c;
    localparam int CTRL_ATTR_EN  = 0;
    localparam int CTRL_MPU_NS   = 1;
    localparam int CTRL_MPU_S    = 2;
    localparam int LIM_EN        = 0;
    localparam int LIM_NSC       = 1;
    localparam int MPU_XN        = 1;
    localparam int MPU_DEV       = 2;
    localparam int MPU_SH        = 3;
    localparam int STS_SEC_FAULT = 0;
    localparam int STS_MM_FAULT  = 1;
    localparam int STS_BUSY      = 8;
    localparam int STS_CFG_PEND  = 9;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  HT_IDLE   = 2'h0;
    localparam logic [1:0]  HT_NONSEQ = 2'h2;

endpackage : msm_pkg

// *** src/msm_unit.sv ***
// Address attribution, security partitioning and AHB issue unit
// Operation
// R1: Attribution units classify every address of the 4GB space Secure or nonsecure.
// R2: Transaction is secure exactly when its address is Secure, independent of core state.
// R3: Nonsecure software access to Secure address is blocked and faults.
// R4: Gateway instruction transitions only when fetched from nonsecure-callable memory.
// R5: Secure software accesses to nonsecure addresses go out as nonsecure.
// R6: Fetches use the MPU bank matching the address attribution.
// R7: Loads and stores use the MPU bank matching the core security state.
// R8: Code region is Normal, non-shareable, executable, allows data.
// R9: SRAM region is Normal, non-shareable, executable.
// R10: Peripheral region is shareable early-ack device memory, no fetches.
// R11: RAM region is Normal, non-shareable, executable.
// R12: External device region is shareable early-ack device, execute-never.
// R13: Private peripheral range is shareable strictly ordered device, execute-never.
// R14: Debug component range is shareable strictly ordered device, execute-never.
// R15: ROM table range is shareable device memory, execute-never.
// R16: Vendor system region is shareable device memory, execute-never.
// R17: Code and upper RAM write-through; SRAM and lower RAM write-back allocate.
// R18: Enabled MPU region attributes override the default map.
// R19: Fetches may be speculative; bus order may differ without barriers.
// R20: Data memory barrier holds later transactions until outstanding ones complete.
// R21: Data sync barrier stalls later instructions until transactions complete.
// R22: Instruction sync barrier makes prior reconfiguration effective afterwards.
// R23: Little-endian: least significant byte at lowest byte address.
// R24: Fetch from execute-never region is not executed and faults.
// R25: Device transactions leave in program order.
// R26: Default attributes are a same-cycle pure function of the address.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module msm_unit
    import msm_pkg::*;
#(
    parameter int          SAU_REGIONS = 4,
    parameter logic        IMPL_DEFINED_ATTRIBUTION_S_EN   = 1'b0,
    parameter logic [31:0] IMPL_DEFINED_ATTRIBUTION_S_BASE = 32'h0000_0000,
    parameter logic [31:0] IMPL_DEFINED_ATTRIBUTION_S_LIM  = 32'h0000_0000
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Core side
    input  wire logic        req_valid_i,
    input  wire msm_req_t    req_i,
    input  wire logic        core_secure_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output msm_rsp_t         rsp_o,
    input  wire logic        dmb_i,
    input  wire logic        dsb_i,
    input  wire logic        isb_i,
    output logic             barrier_stall_o,
    // AHB master toward memory
    output logic [31:0]      m_haddr_o,
    output logic [1:0]       m_htrans_o,
    output logic             m_hwrite_o,
    output logic [2:0]       m_hsize_o,
    output logic [3:0]       m_hprot_o,
    output logic             m_hnonsec_o,
    output logic [31:0]      m_hwdata_o,
    input  wire logic        m_hready_i,
    input  wire logic        m_hresp_i,
    input  wire logic [31:0] m_hrdata_i,
    // AHB-Lite register slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o
);

    // ==========================================================
    // Elaboration check
    // Region words must stay below the MPU words
    if (SAU_REGIONS < 1 || SAU_REGIONS > 6) begin : g_bad_cfg
        $error("SAU_REGIONS must be 1 to 6");
    end

    // ==========================================================
    // Functions
    // Region compare on 32-byte granules
    function automatic logic in_rng(input logic [31:0] a,
                                    input logic [31:0] b,
                                    input logic [31:0] l);
        in_rng = (a[31:5] >= b[31:5]) && (a[31:5] <= l[31:5]);
    endfunction : in_rng

    // R26: pure default lookup
    function automatic msm_attr_t attr_lookup(input logic [31:0] a);
        msm_attr_t r;
        // R13: strictly ordered private and debug ranges, also R14 R15 R16
        r = '{MT_DEV_STRICT, 1'b1, 1'b1, CP_NONE};
        // R8: code, write-through per R17
        if (a < MAP_SRAM) r = '{MT_NORMAL, 1'b0, 1'b0, CP_WT};
        // R9: SRAM, write-back allocate
        else if (a < MAP_PERIPH) r = '{MT_NORMAL, 1'b0, 1'b0, CP_WRITE_BACK_WRITE_ALLOCATE};
        // R10: on-chip peripherals
        else if (a < MAP_RAM) r = '{MT_DEV_EARLY, 1'b1, 1'b1, CP_NONE};
        // R11: lower RAM write-back, upper RAM write-through per R17
        else if (a < MAP_RAM_HI) r = '{MT_NORMAL, 1'b0, 1'b0, CP_WRITE_BACK_WRITE_ALLOCATE};
        else if (a < MAP_EXTDEV) r = '{MT_NORMAL, 1'b0, 1'b0, CP_WT};
        // R12: external devices
        else if (a < MAP_PPB) r = '{MT_DEV_EARLY, 1'b1, 1'b1, CP_NONE};
        attr_lookup = r;
    endfunction : attr_lookup

    // ==========================================================
    // Configuration: shadow written by bus, live used by checks
    logic [31:0] ctrl_sh_q, ctrl_q;
    logic [31:0] sau_b_sh_q [SAU_REGIONS];
    logic [31:0] sau_l_sh_q [SAU_REGIONS];
    logic [31:0] sau_b_q    [SAU_REGIONS];
    logic [31:0] sau_l_q    [SAU_REGIONS];
    logic [31:0] mpu_b_sh_q [2];
    logic [31:0] mpu_l_sh_q [2];
    logic [31:0] mpu_b_q    [2];
    logic [31:0] mpu_l_q    [2];
    logic        cfg_pend_q;
    logic [1:0]  fault_q;
    logic [31:0] faddr_q;

    // ==========================================================
    // Attribution of the presented address
    logic [SAU_REGIONS-1:0] sau_hit;
    logic                   sau_nsc;
    logic                   attr_ns, attr_nsc, sec_addr, impl_defined_attribution_s;

    // First matching region decides callability
    always_comb
    begin
        sau_nsc = 1'b0;
        for (int i = SAU_REGIONS - 1; i >= 0; i--)
        begin
            sau_hit[i] = sau_l_q[i][LIM_EN] &&
                         in_rng(req_i.addr, sau_b_q[i], sau_l_q[i]);
            if (sau_hit[i]) sau_nsc = sau_l_q[i][LIM_NSC];
        end
    end

    // R1: a Secure verdict of the implementation-defined unit overrides a nonsecure SAU verdict, not a callable one
    assign impl_defined_attribution_s   = IMPL_DEFINED_ATTRIBUTION_S_EN && in_rng(req_i.addr, IMPL_DEFINED_ATTRIBUTION_S_BASE, IMPL_DEFINED_ATTRIBUTION_S_LIM);
    assign attr_ns  = ctrl_q[CTRL_ATTR_EN] && (|sau_hit) && !sau_nsc && !impl_defined_attribution_s;
    assign attr_nsc = ctrl_q[CTRL_ATTR_EN] && (|sau_hit) && sau_nsc;
    // R2: secure follows the address only
    assign sec_addr = !attr_ns;

    // ==========================================================
    // MPU bank and attribute selection
    logic      is_fetch, bank_s, mpu_en, mpu_hit;
    msm_attr_t attr_def, attr_eff;

    assign is_fetch = (req_i.kind == AK_FETCH);
    // R6: fetch bank from attribution; R7: data bank from core state
    assign bank_s   = is_fetch ? sec_addr : core_secure_i;
    assign mpu_en   = bank_s ? ctrl_q[CTRL_MPU_S] : ctrl_q[CTRL_MPU_NS];
    assign mpu_hit  = mpu_en && mpu_l_q[bank_s][LIM_EN] &&
                      in_rng(req_i.addr, mpu_b_q[bank_s], mpu_l_q[bank_s]);
    assign attr_def = attr_lookup(req_i.addr);

    // R18: a hit in the chosen bank replaces type, shareability and execute-never; cache policy only for device
    always_comb
    begin
        attr_eff = attr_def;
        if (mpu_hit)
        begin
            attr_eff.mtype         = mpu_l_q[bank_s][MPU_DEV] ? MT_DEV_EARLY : MT_NORMAL;
            attr_eff.shareable     = mpu_l_q[bank_s][MPU_SH] || mpu_l_q[bank_s][MPU_DEV];
            attr_eff.execute_never = mpu_l_q[bank_s][MPU_XN];
            attr_eff.cache         = mpu_l_q[bank_s][MPU_DEV] ? CP_NONE : attr_def.cache;
        end
    end

    // ==========================================================
    // Access checks
    logic sec_flt, mm_flt, take, any_flt;

    // R3: nonsecure code may only fetch callable entry points
    assign sec_flt = !core_secure_i && sec_addr && !(is_fetch && attr_nsc);
    // R24: execute-never fetch faults instead of issuing
    assign mm_flt  = is_fetch && attr_eff.execute_never && !sec_flt;
    assign any_flt = sec_flt || mm_flt;

    // ==========================================================
    // Issue state machine, one transaction outstanding
    msm_state_t  st_q, st_d;
    logic        dmb_q, dsb_q, busy;
    logic [1:0]  lane_q, size_q;
    logic        gw_q;

    assign busy            = (st_q != S_IDLE);
    // R20: a pending barrier holds new transactions
    assign req_ready_o     = !busy && !dmb_q && !dsb_q;
    assign take            = req_valid_i && req_ready_o;
    assign barrier_stall_o = dsb_q;

    // R25: serial issue keeps device order; R19 fetches ride the same path
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            S_IDLE: if (take && !any_flt) st_d = S_ADDR;
            S_ADDR: if (m_hready_i) st_d = S_DATA;
            S_DATA: if (m_hready_i) st_d = S_IDLE;
            default: st_d = S_IDLE;
        endcase
    end

    // Barrier flags clear once the path is empty
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st_q  <= S_IDLE;
            dmb_q <= 1'b0;
            dsb_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            // R20: hold later transactions
            dmb_q <= dmb_i || (dmb_q && busy);
            // R21: stall instructions
            dsb_q <= dsb_i || (dsb_q && busy);
        end
    end

    // Bus address and data phase drive
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            m_htrans_o  <= HT_IDLE;
            m_haddr_o   <= RST_WORD;
            m_hwrite_o  <= 1'b0;
            m_hsize_o   <= 3'h0;
            m_hprot_o   <= 4'h0;
            m_hnonsec_o <= 1'b0;
            m_hwdata_o  <= RST_WORD;
            lane_q      <= 2'h0;
            size_q      <= 2'h0;
            gw_q        <= 1'b0;
        end
        else if (take && !any_flt)
        begin
            m_htrans_o  <= HT_NONSEQ;
            m_haddr_o   <= req_i.addr;
            m_hwrite_o  <= (req_i.kind == AK_STORE);
            m_hsize_o   <= {1'b0, req_i.size};
            m_hprot_o   <= {attr_eff.cache != CP_NONE,
                            attr_eff.mtype != MT_DEV_STRICT, 1'b1, !is_fetch};
            // R5: nonsecure address goes out nonsecure
            m_hnonsec_o <= attr_ns;
            // R23: low byte of the register lands on the addressed lane
            m_hwdata_o  <= req_i.wdata << {req_i.addr[1:0], 3'h0};
            lane_q      <= req_i.addr[1:0];
            size_q      <= req_i.size;
            // R4: only callable fetches may switch state
            gw_q        <= is_fetch && attr_nsc;
        end
        else if (st_q == S_ADDR && m_hready_i)
        begin
            m_htrans_o <= HT_IDLE;
        end
    end

    // Response: fault at once, or read data at the last data edge
    logic [31:0] rd_sh;
    assign rd_sh = m_hrdata_i >> {lane_q, 3'h0};

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end
        else if (take && any_flt)
        begin
            rsp_valid_o <= 1'b1;
            rsp_o       <= '{RST_WORD, sec_flt, mm_flt, 1'b0, 1'b0};
        end
        else if (st_q == S_DATA && m_hready_i)
        begin
            rsp_valid_o <= 1'b1;
            // R23: lane back to register order, then size mask
            rsp_o.rdata <= (size_q == 2'h0) ? {24'h0, rd_sh[7:0]} :
                           (size_q == 2'h1) ? {16'h0, rd_sh[15:0]} : rd_sh;
            rsp_o.sec_fault  <= 1'b0;
            rsp_o.mm_fault   <= 1'b0;
            rsp_o.gateway_ok <= gw_q;
            rsp_o.bus_err    <= m_hresp_i;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
        end
    end

    // ==========================================================
    // Register slave, reads take one wait state
    logic       s_acc, s_wr_q, s_rd_q;
    logic [7:0] s_ad_q;
    logic [31:0] rd_mux;

    assign s_acc       = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = !s_rd_q;
    assign hresp_o     = 1'b0;

    // Read decode, unmapped words read zero
    always_comb
    begin
        rd_mux = RST_WORD;
        case (s_ad_q)
            OFS_CTRL:     rd_mux = ctrl_sh_q;
            OFS_STATUS:   rd_mux = {22'h0, cfg_pend_q, busy, 6'h0, fault_q};
            OFS_FADDR:    rd_mux = faddr_q;
            OFS_MPU_NS_B: rd_mux = mpu_b_sh_q[0];
            OFS_MPU_NS_L: rd_mux = mpu_l_sh_q[0];
            OFS_MPU_S_B:  rd_mux = mpu_b_sh_q[1];
            OFS_MPU_S_L:  rd_mux = mpu_l_sh_q[1];
            default:      rd_mux = RST_WORD;
        endcase
        for (int i = 0; i < SAU_REGIONS; i++)
        begin
            if (s_ad_q == OFS_SAU + 8'(8 * i)) rd_mux = sau_b_sh_q[i];
            if (s_ad_q == OFS_SAU + 8'(8 * i + 4)) rd_mux = sau_l_sh_q[i];
        end
    end

    // Phase tracking for the slave
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            s_wr_q   <= 1'b0;
            s_rd_q   <= 1'b0;
            s_ad_q   <= 8'h0;
            hrdata_o <= RST_WORD;
        end
        else
        begin
            s_wr_q <= s_acc && hwrite_i;
            s_rd_q <= s_acc && !hwrite_i;
            if (s_acc) s_ad_q <= {haddr_i[7:2], 2'h0};
            if (s_rd_q) hrdata_o <= rd_mux;
        end
    end

    // Shadow writes, live copy on the sync barrier
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            ctrl_sh_q  <= RST_WORD;
            ctrl_q     <= RST_WORD;
            cfg_pend_q <= 1'b0;
            mpu_b_sh_q <= '{default: RST_WORD};
            mpu_l_sh_q <= '{default: RST_WORD};
            mpu_b_q    <= '{default: RST_WORD};
            mpu_l_q    <= '{default: RST_WORD};
            sau_b_sh_q <= '{default: RST_WORD};
            sau_l_sh_q <= '{default: RST_WORD};
            sau_b_q    <= '{default: RST_WORD};
            sau_l_q    <= '{default: RST_WORD};
        end
        else
        begin
            if (s_wr_q)
            begin
                if (s_ad_q == OFS_CTRL) ctrl_sh_q <= hwdata_i;
                if (s_ad_q == OFS_MPU_NS_B) mpu_b_sh_q[0] <= hwdata_i;
                if (s_ad_q == OFS_MPU_NS_L) mpu_l_sh_q[0] <= hwdata_i;
                if (s_ad_q == OFS_MPU_S_B) mpu_b_sh_q[1] <= hwdata_i;
                if (s_ad_q == OFS_MPU_S_L) mpu_l_sh_q[1] <= hwdata_i;
                for (int i = 0; i < SAU_REGIONS; i++)
                begin
                    if (s_ad_q == OFS_SAU + 8'(8 * i)) sau_b_sh_q[i] <= hwdata_i;
                    if (s_ad_q == OFS_SAU + 8'(8 * i + 4)) sau_l_sh_q[i] <= hwdata_i;
                end
            end
            // R22: reconfiguration takes effect after the barrier
            if (isb_i)
            begin
                ctrl_q  <= ctrl_sh_q;
                mpu_b_q <= mpu_b_sh_q;
                mpu_l_q <= mpu_l_sh_q;
                sau_b_q <= sau_b_sh_q;
                sau_l_q <= sau_l_sh_q;
            end
            // A write in the barrier cycle stays pending
            cfg_pend_q <= s_wr_q || (cfg_pend_q && !isb_i);
        end
    end

    // Sticky faults, write one to clear, a new fault wins
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            fault_q <= 2'h0;
            faddr_q <= RST_WORD;
        end
        else
        begin
            fault_q <= (fault_q & ~((s_wr_q && s_ad_q == OFS_STATUS) ?
                        hwdata_i[1:0] : 2'h0)) |
                       ((take) ? {mm_flt, sec_flt} : 2'h0);
            if (take && any_flt) faddr_q <= req_i.addr;
        end
    end

    // ==========================================================
    // Checks
    // R3: blocked access
    chk_sec_block: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && sec_flt |=> rsp_valid_o && rsp_o.sec_fault && m_htrans_o == HT_IDLE)
        else $error("secure access leaked to bus");
    // R5: nonsecure marking
    chk_nonsec_mark: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && !any_flt |=> m_hnonsec_o == !$past(sec_addr))
        else $error("nonsecure marking wrong");
    // R24: execute-never fetch
    chk_xn_fetch: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && is_fetch && attr_eff.execute_never && !sec_flt |=> rsp_o.mm_fault)
        else $error("execute-never fetch not faulted");
    // R10: peripheral fetch
    chk_periph_xn: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && is_fetch && !sec_flt && !mpu_hit && req_i.addr[31:29] == 3'h2
        |=> rsp_valid_o && rsp_o.mm_fault)
        else $error("peripheral fetch allowed");
    // R17: SRAM cache policy
    chk_sram_cache: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && !any_flt && !mpu_hit && req_i.addr[31:29] == 3'h1
        |=> m_hprot_o[3:2] == 2'h3)
        else $error("SRAM not cacheable");
    // R4: gateway outside callable memory
    chk_gateway: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && !any_flt && !attr_nsc |=> !gw_q)
        else $error("gateway allowed outside callable memory");
    // R20: barrier hold
    chk_dmb_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
        dmb_i |=> !req_ready_o)
        else $error("request taken past barrier");
    // R21: stall and busy both held the cycle after the barrier
    chk_dsb_stall: assert property (@(posedge mclk_i) disable iff (reset_i)
        dsb_i && busy |=> barrier_stall_o [*1] ##0 (busy || !$past(busy)))
        else $error("sync barrier stall missing");
    // R22: live config after barrier
    chk_isb_apply: assert property (@(posedge mclk_i) disable iff (reset_i)
        isb_i && !s_wr_q |=> ctrl_q == $past(ctrl_sh_q) && !cfg_pend_q)
        else $error("config not applied at barrier");
    // R23: byte lane placement
    chk_le_store: assert property (@(posedge mclk_i) disable iff (reset_i)
        take && !any_flt && req_i.size == 2'h0 && req_i.addr[1:0] == 2'h3
        |=> m_hwdata_o[31:24] == $past(req_i.wdata[7:0]))
        else $error("store byte on wrong lane");
    // R25: single outstanding transfer
    chk_serial: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q == S_DATA |-> m_htrans_o == HT_IDLE && !req_ready_o)
        else $error("second transfer overlapped");

endmodule : msm_unit

// *** verification/msm_mem_model.sv ***
// AHB memory model on the far side of the unit's bus master
`timescale 1ns/1ps
module msm_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        slow_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    output logic             hready_o,
    output logic [31:0]      hrdata_o
);
    logic        ph_q, wr_q;
    logic [1:0]  cnt_q;
    logic [3:0]  ix_q;
    logic [31:0] mem_q [16];
    // Junk outside the read cycle keeps stale data out
    assign hready_o = !ph_q || cnt_q == 2'h0;
    assign hrdata_o = (ph_q && hready_o && !wr_q) ? mem_q[ix_q] : ~mem_q[ix_q];
    // Slow mode adds two wait states to each data phase
    always_ff @(posedge mclk_i)
    begin
        if (ph_q && hready_o && wr_q)
            mem_q[ix_q] <= hwdata_i;
        if (reset_i)
            ph_q <= 1'b0;
        else if (hready_o)
            {ph_q, wr_q, ix_q, cnt_q} <= {htrans_i[1], hwrite_i, haddr_i[5:2], slow_i, 1'b0};
        else
            cnt_q <= cnt_q - 2'h1;
    end
endmodule : msm_mem_model

// *** verification/msm_unit_tb.sv ***
// Self-checking bench of the memory attribute and security map unit
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module msm_unit_tb;
    import msm_pkg::*;
    logic mclk_i = 0, reset_i = 1, req_valid_i = 0, core_secure_i = 0, slow = 0, bus, ns;
    logic dmb_i = 0, dsb_i = 0, isb_i = 0, hsel_i = 0, hwrite_i = 0;
    logic [1:0] htrans_i = 0;
    logic [3:0] prot;
    logic [31:0] haddr_i = 0, hwdata_i = 0, rd;
    msm_req_t req_i = '0;
    msm_rsp_t rsp, rsp_o;
    wire logic req_ready_o, rsp_valid_o, barrier_stall_o, m_hwrite_o, m_hnonsec_o, m_hready_i;
    wire logic hreadyout_o, hresp_o;
    wire logic [1:0] m_htrans_o;
    wire logic [2:0] m_hsize_o;
    wire logic [3:0] m_hprot_o;
    wire logic [31:0] m_haddr_o, m_hwdata_o, m_hrdata_i, hrdata_o;
    int num_errors = 0, checks = 0;
    always #5 mclk_i = ~mclk_i;
    msm_unit u_dut (.mclk_i, .reset_i, .req_valid_i, .req_i, .core_secure_i, .req_ready_o,
        .rsp_valid_o, .rsp_o, .dmb_i, .dsb_i, .isb_i, .barrier_stall_o, .m_haddr_o, .m_htrans_o,
        .m_hwrite_o, .m_hsize_o, .m_hprot_o, .m_hnonsec_o, .m_hwdata_o, .m_hready_i,
        .m_hresp_i(1'b0), .m_hrdata_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o);
    msm_mem_model u_mem (.mclk_i, .reset_i, .slow_i(slow), .haddr_i(m_haddr_o),
        .htrans_i(m_htrans_o), .hwrite_i(m_hwrite_o), .hwdata_i(m_hwdata_o),
        .hready_o(m_hready_i), .hrdata_o(m_hrdata_i));
    // ==========================================================
    // Bus tasks, entered right after a rising edge
    task end_of_test();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Ready is judged before the edge, so no race with the slave's update
    task rdy();
        do @(negedge mclk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        @(posedge mclk_i);
    endtask : rdy
    task reg_acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        {hsel_i, haddr_i, htrans_i, hwrite_i} <= {1'b1, a, HT_NONSEQ, w};
        rdy();
        {hsel_i, htrans_i, hwdata_i} <= {1'b0, HT_IDLE, d};
        rdy();
    endtask : reg_acc
    task core(input logic [31:0] a, input msm_kind_t k, input logic [1:0] s,
              input logic [31:0] w, input logic sec);
        {req_valid_i, req_i, core_secure_i, bus} <= {1'b1, a, k, s, w, sec, 1'b0};
        do @(negedge mclk_i); while (req_ready_o !== 1'b1);
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        do
        begin
            @(negedge mclk_i);
            if (m_htrans_o == HT_NONSEQ)
                {bus, prot, ns} = {1'b1, m_hprot_o, m_hnonsec_o};
        end while (rsp_valid_o !== 1'b1);
        rsp = rsp_o;
        @(posedge mclk_i);
    endtask : core
    // ==========================================================
    // Scenarios
    task t_endian();
        core(32'h2000_0000, AK_STORE, 2'h2, 32'h4433_2211, 1'b1);
        slow <= 1'b1;
        core(32'h2000_0001, AK_LOAD, 2'h0, 0, 1'b1);
        `CHK(rsp.rdata, 32'h0000_0022)
        core(32'h2000_0002, AK_LOAD, 2'h1, 0, 1'b1);
        `CHK(rsp.rdata, 32'h0000_4433)
        slow <= 1'b0;
    endtask : t_endian
    task automatic t_attr();
        logic [31:0] a [4] = '{32'h0000_0010, 32'h4000_0000, 32'he000_0000, 32'h2000_0004};
        logic [3:0] p [4] = '{4'hf, 4'h7, 4'h3, 4'he};
        for (int i = 0; i < 4; i++)
        begin
            core(a[i], i == 3 ? AK_FETCH : AK_LOAD, 2'h2, 0, 1'b1);
            `CHK({bus, prot}, {1'b1, p[i]})
        end
    endtask : t_attr
    task automatic t_xn();
        logic [31:0] a [3] = '{32'h4000_0000, 32'ha000_0000, 32'he010_0000};
        for (int i = 0; i < 3; i++)
        begin
            core(a[i], AK_FETCH, 2'h2, 0, 1'b1);
            `CHK({bus, rsp.mm_fault}, 2'b01)
        end
    endtask : t_xn
    task t_barrier();
        dmb_i <= 1'b1;
        @(posedge mclk_i) dmb_i <= 1'b0;
        @(negedge mclk_i) `CHK(req_ready_o, 1'b0)
        @(posedge mclk_i) dsb_i <= 1'b1;
        @(posedge mclk_i) dsb_i <= 1'b0;
        @(negedge mclk_i) `CHK(barrier_stall_o, 1'b1)
        repeat (4) @(posedge mclk_i);
    endtask : t_barrier
    task t_secure();
        core(32'h2000_0000, AK_LOAD, 2'h2, 0, 1'b0);
        `CHK({bus, rsp.sec_fault}, 2'b01)
        reg_acc(1'b1, 32'h10, 32'h2000_0000);
        reg_acc(1'b1, 32'h14, 32'h2000_0fe1);
        reg_acc(1'b1, 32'h18, 32'h1000_0000);
        reg_acc(1'b1, 32'h1c, 32'h1000_0fe3);
        reg_acc(1'b1, 32'h48, 32'h3000_0000);
        reg_acc(1'b1, 32'h4c, 32'h3000_0fe5);
        reg_acc(1'b1, 32'h00, 32'h5);
        reg_acc(1'b0, 32'h1c, 0);
        `CHK(rd, 32'h1000_0fe3)
        reg_acc(1'b0, 32'hfc, 0);
        `CHK({rd, hresp_o}, 33'h0)
        isb_i <= 1'b1;
        @(posedge mclk_i) isb_i <= 1'b0;
        @(posedge mclk_i) core(32'h2000_0004, AK_LOAD, 2'h2, 0, 1'b1);
        `CHK({ns, rsp.sec_fault}, 2'b10)
        core(32'h3000_0000, AK_LOAD, 2'h2, 0, 1'b1);
        `CHK({ns, prot}, 5'h07)
        core(32'h3000_0000, AK_STORE, 2'h2, 0, 1'b0);
        `CHK({bus, rsp.sec_fault}, 2'b01)
        core(32'h1000_0000, AK_FETCH, 2'h2, 0, 1'b0);
        `CHK(rsp.gateway_ok, 1'b1)
    endtask : t_secure
    initial
    begin
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        t_endian();
        t_attr();
        t_xn();
        t_barrier();
        t_secure();
        end_of_test();
    end
    // Whole run needs under two hundred cycles
    initial
    begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule : msm_unit_tb
